// ==== logic/msd_pkg.sv ====
// shared constants and types of the memory space decoder
package msd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and standby timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int STBY_TIME_NS  = 70;   // quiet time before array standby
   // a least time, so round up to whole cycles
   localparam int STBY_CYC      =
      (STBY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STBY_CNT_W    = 5;

   ////////////////////////////////////////////////////////////////////////
   // configuration register window offsets (low address byte)
   localparam logic [7:0] PAGE_OFS      = 8'hE0;
   localparam logic [7:0] SPACE_MAP_OFS = 8'hE2;
   localparam logic [7:0] PAGE_RST      = 8'h00;
   localparam logic [7:0] SPACE_MAP_RST = 8'h00;

   // space map field positions
   localparam int MAP_RAM_CODE  = 0;
   localparam int MAP_SEC_CODE  = 1;
   localparam int MAP_PRIM_CODE = 2;
   localparam int MAP_SEC_DATA  = 3;
   localparam int MAP_PRIM_DATA = 4;
   localparam int MAP_PERIPHERAL_IO_MODE_ENABLE    = 7;
   localparam logic [7:0] MAP_USED_MASK = 8'h9F;  // bits 5 and 6 unused

   ////////////////////////////////////////////////////////////////////////
   // logic-array input bus layout
   localparam int BUS_W         = 73;
   localparam int BUS_ADDR_LSB  = 0;
   localparam int BUS_WR        = 16;
   localparam int BUS_RD        = 17;
   localparam int BUS_FETCH     = 18;
   localparam int BUS_RST       = 19;
   localparam int BUS_PDN       = 20;
   localparam int BUS_PORT_LSB  = 21;
   localparam int BUS_PORTD_LSB = 45;
   localparam int BUS_PAGE_LSB  = 48;
   localparam int BUS_FB_LSB    = 56;
   localparam int BUS_READY     = 72;
   localparam int EXT_ADDR_LSB  = 4;

   // control blocking bit positions
   localparam int BLK_WR        = 0;
   localparam int BLK_RD        = 1;
   localparam int BLK_FETCH     = 2;
   localparam int BLK_RST       = 3;
   localparam int BLK_PDN       = 4;

   ////////////////////////////////////////////////////////////////////////
   // product term layout of the decode array
   localparam int NUM_PRIM      = 8;
   localparam int NUM_SEC       = 4;
   localparam int PT_SECTOR     = 3;
   localparam int PT_RAM        = 2;
   localparam int NUM_PERIPH    = 2;
   localparam int T_PRIM_BASE   = 0;
   localparam int T_SEC_BASE    = T_PRIM_BASE + NUM_PRIM * PT_SECTOR;
   localparam int T_RAM_BASE    = T_SEC_BASE + NUM_SEC * PT_SECTOR;
   localparam int T_CFG         = T_RAM_BASE + PT_RAM;
   localparam int T_JTAG        = T_CFG + 1;
   localparam int T_PERIPH_BASE = T_JTAG + 1;
   localparam int NUM_TERMS     = T_PERIPH_BASE + NUM_PERIPH;

   // power state of the logic arrays
   typedef enum logic {
      PWR_ACTIVE,
      PWR_STANDBY
   } msd_pwr_type;

endpackage

// ==== logic/msd_term_array.sv ====
// product term array: one masked compare per term over the input bus
`timescale 1ns/1ps

module msd_term_array #(
   parameter int                   NT    = 42,
   parameter int                   BW    = 73,
   parameter logic [NT*BW-1:0]     MASK  = '0,
   parameter logic [NT*BW-1:0]     VALUE = '0,
   parameter logic [NT-1:0]        EN    = '0
) (
   // array inputs
   input  wire logic [BW-1:0]      i_bus,
   // product terms
   output logic      [NT-1:0]      o_terms
);

   ////////////////////////////////////////////////////////////////////////
   // a term with its enable low never fires, whatever its mask says
   for (genvar g = 0; g < NT; g++) begin : g_term
      assign o_terms[g] = EN[g] &
         ((i_bus & MASK[g*BW +: BW]) == VALUE[g*BW +: BW]);
   end

endmodule // msd_term_array

// ==== logic/msd_decoder.sv ====
// memory space decoder: space map, page register and decode array
// What this block does
// - each flash may sit in fetch space, data space or both via map; ram is always in data space, fetch via map
// - space map loads boot value, MCU may rewrite it any time
// - map bits: 0 ram fetch,1/2 sec/prim fetch,3/4 sec/prim data,7 pio
// - eight-bit page register, written and read back over data bits
// - page register answers at offset E0 in config window
// - page bits feed decode array inputs for sector and ram selects
// - page bits also go out to the general logic array
// - without fast mode, array sleeps after 70 ns quiet, adding delay
// - five blocking bits keep control signals out of the arrays
// - array input bus carries the 73 listed signals
// - extended address mode takes address bits 19 down to 4
// - eight primary and four secondary sector selects, three terms each
// - ram select from two terms, plus config window select
// - one select enables jtag on port c
// - two peripheral selects used in peripheral io mode
// - secondary sector wins over an overlapping primary sector
// - ram, io or peripheral io win over any flash sector
`timescale 1ns/1ps

module msd_decoder #(
   parameter int NT = msd_pkg::NUM_TERMS,
   parameter int BW = msd_pkg::BUS_W,
   parameter logic [NT*BW-1:0] TERM_MASK  = '0,
   parameter logic [NT*BW-1:0] TERM_VALUE = '0,
   parameter logic [NT-1:0]    TERM_EN    = '0
) (
   // clock, reset, enable
   input  wire logic         I_REF_CLK,
   input  wire logic         I_RST_N,
   input  wire logic         I_CLK_EN,
   // mcu bus pins
   input  wire logic [19:0]  I_ADDR,
   input  wire logic [7:0]   I_DATA,
   output logic      [7:0]   O_DATA,
   output logic              O_DATA_OE,
   input  wire logic         I_WRITE_STROBE_N,
   input  wire logic         I_BUS_CONTROL_LINE_1_N,
   input  wire logic         I_PROGRAM_FETCH_STROBE_N,
   input  wire logic         I_MCU_RESET_N,
   input  wire logic         I_POWER_DOWN_INPUT,
   // other array input pins
   input  wire logic [23:0]  I_PORT_MACROCELLS,
   input  wire logic [2:0]   I_PORT_D,
   input  wire logic [15:0]  I_MACROCELL_FB,
   input  wire logic         I_SECONDARY_READY,
   // configuration levels from the same clock domain
   input  wire logic [7:0]   I_SPACE_MAP_INIT,
   input  wire logic         I_EXT_ADDR_MODE,
   input  wire logic         I_FAST_MODE,
   input  wire logic [4:0]   I_CTRL_BLOCK,
   // decoded selects
   output logic      [7:0]   O_PRIMARY_SECTOR_SELECTS,
   output logic      [3:0]   O_SECONDARY_SECTOR_SELECTS,
   output logic              O_RAM_SELECT,
   output logic              O_CONFIG_REG_WINDOW,
   output logic              O_JTAG_SELECT,
   output logic      [1:0]   O_PERIPH_SELECTS,
   // state seen by other logic
   output logic      [7:0]   O_PAGE_BITS,
   output logic              O_PERIPHERAL_IO_MODE_ENABLE,
   output logic              O_ARRAY_STANDBY
);

   localparam int SYNC_W = 77;
   localparam logic [msd_pkg::STBY_CNT_W-1:0] STBY_LAST =
      msd_pkg::STBY_CNT_W'(msd_pkg::STBY_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser; strobes idle high so reset loads all ones
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [19:0]       s_addr;
   logic [7:0]        s_data;
   logic              s_wr_n;
   logic              s_rd_n;
   logic              s_fetch_n;
   logic              s_mrst_n;
   logic              s_pdn;
   logic [23:0]       s_port;
   logic [2:0]        s_portd;
   logic [15:0]       s_fb;
   logic              s_ready;

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else if (I_CLK_EN) begin
         sync1_reg <= {I_ADDR, I_DATA, I_WRITE_STROBE_N,
                       I_BUS_CONTROL_LINE_1_N, I_PROGRAM_FETCH_STROBE_N,
                       I_MCU_RESET_N, I_POWER_DOWN_INPUT, I_PORT_MACROCELLS,
                       I_PORT_D, I_MACROCELL_FB, I_SECONDARY_READY};
         sync2_reg <= sync1_reg;
      end
   end

   assign {s_addr, s_data, s_wr_n, s_rd_n, s_fetch_n, s_mrst_n, s_pdn,
           s_port, s_portd, s_fb, s_ready} = sync2_reg;

   ////////////////////////////////////////////////////////////////////////
   // strobes as active-high levels
   logic wr_act;
   logic rd_act;
   logic fetch_act;

   assign wr_act    = ~s_wr_n;
   assign rd_act    = ~s_rd_n;
   assign fetch_act = ~s_fetch_n;

   ////////////////////////////////////////////////////////////////////////
   // array input bus; blocked controls read as inactive
   logic [7:0]    page_reg;
   logic [15:0]   arr_addr;
   logic [2:0]    arr_cntl;
   logic          arr_rst;
   logic          arr_pdn;
   logic [BW-1:0] arr_bus;

   assign arr_addr = I_EXT_ADDR_MODE ?
      s_addr[msd_pkg::EXT_ADDR_LSB +: 16] : s_addr[15:0];
   assign arr_cntl = {fetch_act & ~I_CTRL_BLOCK[msd_pkg::BLK_FETCH],
                      rd_act    & ~I_CTRL_BLOCK[msd_pkg::BLK_RD],
                      wr_act    & ~I_CTRL_BLOCK[msd_pkg::BLK_WR]};
   assign arr_rst  = ~s_mrst_n & ~I_CTRL_BLOCK[msd_pkg::BLK_RST];
   assign arr_pdn  = s_pdn & ~I_CTRL_BLOCK[msd_pkg::BLK_PDN];
   // page bits take part in the decode equations
   assign arr_bus  = {s_ready, s_fb, page_reg, s_portd, s_port,
                      arr_pdn, arr_rst, arr_cntl, arr_addr};

   ////////////////////////////////////////////////////////////////////////
   // decode array product terms
   logic [NT-1:0] terms;

   msd_term_array #(
      .NT    (NT),
      .BW    (BW),
      .MASK  (TERM_MASK),
      .VALUE (TERM_VALUE),
      .EN    (TERM_EN)
   ) u_terms (
      .i_bus   (arr_bus),
      .o_terms (terms)
   );

   // or of a group of product terms
   function automatic logic grp_any(input logic [NT-1:0] t,
                                    input int base, input int n);
      logic r;
      r = 1'b0;
      for (int k = 0; k < msd_pkg::PT_SECTOR; k++) begin
         if (k < n) begin
            r = r | t[base + k];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // raw decoded selects, before space map and priority
   logic [7:0] dec_prim;
   logic [3:0] dec_sec;
   logic       dec_ram;
   logic       dec_cfg;
   logic       dec_jtag;
   logic [1:0] dec_periph;

   for (genvar p = 0; p < msd_pkg::NUM_PRIM; p++) begin : g_prim
      assign dec_prim[p] = grp_any(terms,
         msd_pkg::T_PRIM_BASE + p * msd_pkg::PT_SECTOR, msd_pkg::PT_SECTOR);
   end
   for (genvar s = 0; s < msd_pkg::NUM_SEC; s++) begin : g_sec
      assign dec_sec[s] = grp_any(terms,
         msd_pkg::T_SEC_BASE + s * msd_pkg::PT_SECTOR, msd_pkg::PT_SECTOR);
   end
   assign dec_ram    = grp_any(terms, msd_pkg::T_RAM_BASE,
                               msd_pkg::PT_RAM);
   assign dec_cfg    = terms[msd_pkg::T_CFG];
   assign dec_jtag   = terms[msd_pkg::T_JTAG];
   assign dec_periph = terms[msd_pkg::T_PERIPH_BASE +: 2];

   ////////////////////////////////////////////////////////////////////////
   // space map gating and overlap priority
   logic [7:0] space_map_reg;
   logic       ram_ok;
   logic       prim_ok;
   logic       sec_ok;
   logic [1:0] periph_next;
   logic       high_prio;
   logic [7:0] prim_next;
   logic [3:0] sec_next;
   logic       ram_next;

   // writes pass to every memory so flash commands are never masked
   assign ram_ok   = wr_act | rd_act |
                     (fetch_act & space_map_reg[msd_pkg::MAP_RAM_CODE]);
   assign prim_ok  = wr_act |
                     (fetch_act & space_map_reg[msd_pkg::MAP_PRIM_CODE]) |
                     (rd_act & space_map_reg[msd_pkg::MAP_PRIM_DATA]);
   assign sec_ok   = wr_act |
                     (fetch_act & space_map_reg[msd_pkg::MAP_SEC_CODE]) |
                     (rd_act & space_map_reg[msd_pkg::MAP_SEC_DATA]);
   assign periph_next = dec_periph &
                        {2{space_map_reg[msd_pkg::MAP_PERIPHERAL_IO_MODE_ENABLE]}};
   // priority uses the raw decode so a masked ram still hides flash
   assign high_prio = dec_ram | dec_cfg | (|periph_next);
   assign prim_next = dec_prim &
                      {8{prim_ok & ~high_prio & ~(|dec_sec)}};
   assign sec_next  = dec_sec & {4{sec_ok & ~high_prio}};
   assign ram_next  = dec_ram & ram_ok;

   ////////////////////////////////////////////////////////////////////////
   // quiet-input detection for standby
   logic [BW-1:0]                     bus_prev_reg;
   logic                              changed;
   logic [msd_pkg::STBY_CNT_W-1:0]    idle_reg;
   logic [msd_pkg::STBY_CNT_W-1:0]    idle_next;
   msd_pkg::msd_pwr_type              pwr_reg;
   msd_pkg::msd_pwr_type              pwr_next;
   logic                              upd;

   assign changed   = arr_bus != bus_prev_reg;
   assign idle_next = (changed || I_FAST_MODE) ? '0 :
                      (idle_reg == STBY_LAST) ? idle_reg : idle_reg + 1'b1;
   assign upd       = pwr_reg == msd_pkg::PWR_ACTIVE;

   // a wake costs one cycle: the selects follow the bus one edge later
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         msd_pkg::PWR_ACTIVE: begin
            if (!I_FAST_MODE && !changed && idle_reg == STBY_LAST) begin
               pwr_next = msd_pkg::PWR_STANDBY;
            end
         end
         msd_pkg::PWR_STANDBY: begin
            if (changed || I_FAST_MODE) begin
               pwr_next = msd_pkg::PWR_ACTIVE;
            end
         end
         default: pwr_next = msd_pkg::PWR_ACTIVE;
      endcase
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         bus_prev_reg <= '0;
         idle_reg     <= '0;
         pwr_reg      <= msd_pkg::PWR_ACTIVE;
      end else if (I_CLK_EN) begin
         bus_prev_reg <= arr_bus;
         idle_reg     <= idle_next;
         pwr_reg      <= pwr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // select outputs, frozen while the array sleeps
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRIMARY_SECTOR_SELECTS   <= '0;
         O_SECONDARY_SECTOR_SELECTS <= '0;
         O_RAM_SELECT               <= 1'b0;
         O_CONFIG_REG_WINDOW        <= 1'b0;
         O_JTAG_SELECT              <= 1'b0;
         O_PERIPH_SELECTS           <= '0;
      end else if (I_CLK_EN && upd) begin
         O_PRIMARY_SECTOR_SELECTS   <= prim_next;
         O_SECONDARY_SECTOR_SELECTS <= sec_next;
         O_RAM_SELECT               <= ram_next;
         O_CONFIG_REG_WINDOW        <= dec_cfg;
         O_JTAG_SELECT              <= dec_jtag;
         O_PERIPH_SELECTS           <= periph_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // config window register access; writes land on the strobe's leading edge
   logic wr_prev_reg;
   logic wr_pulse;
   logic page_hit;
   logic map_hit;
   logic rd_hit;
   logic boot_pend_reg;

   assign wr_pulse = wr_act & ~wr_prev_reg;
   assign page_hit = dec_cfg && s_addr[7:0] == msd_pkg::PAGE_OFS;
   assign map_hit  = dec_cfg && s_addr[7:0] == msd_pkg::SPACE_MAP_OFS;
   assign rd_hit   = rd_act & (page_hit | map_hit);

   // boot value is taken on the first enabled edge after reset release
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wr_prev_reg   <= 1'b0;
         boot_pend_reg <= 1'b1;
         page_reg      <= msd_pkg::PAGE_RST;
         space_map_reg <= msd_pkg::SPACE_MAP_RST;
      end else if (I_CLK_EN) begin
         wr_prev_reg   <= wr_act;
         boot_pend_reg <= 1'b0;
         if (boot_pend_reg) begin
            space_map_reg <= I_SPACE_MAP_INIT & msd_pkg::MAP_USED_MASK;
         end else if (wr_pulse && map_hit) begin
            space_map_reg <= s_data & msd_pkg::MAP_USED_MASK;
         end
         if (wr_pulse && page_hit) begin
            page_reg <= s_data;
         end
      end
   end

   // read-back drives the data bus one edge after the synchronised read strobe hits a window register
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DATA    <= '0;
         O_DATA_OE <= 1'b0;
      end else if (I_CLK_EN) begin
         O_DATA_OE <= rd_hit;
         O_DATA    <= page_hit ? page_reg :
                      map_hit ? space_map_reg : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status outputs
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PAGE_BITS                 <= msd_pkg::PAGE_RST;
         O_PERIPHERAL_IO_MODE_ENABLE <= 1'b0;
         O_ARRAY_STANDBY             <= 1'b0;
      end else if (I_CLK_EN) begin
         O_PAGE_BITS                 <= page_reg;
         O_PERIPHERAL_IO_MODE_ENABLE <= space_map_reg[msd_pkg::MAP_PERIPHERAL_IO_MODE_ENABLE];
         O_ARRAY_STANDBY             <= pwr_next == msd_pkg::PWR_STANDBY;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   property p_sec_wins;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (|O_SECONDARY_SECTOR_SELECTS) |-> O_PRIMARY_SECTOR_SELECTS == '0;
   endproperty
   a_sec_wins: assert property (p_sec_wins)
      else $error("primary and secondary sectors both selected");

   property p_high_wins;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (O_RAM_SELECT || O_CONFIG_REG_WINDOW || (|O_PERIPH_SELECTS)) |->
         (O_PRIMARY_SECTOR_SELECTS == '0 && O_SECONDARY_SECTOR_SELECTS == '0);
   endproperty
   a_high_wins: assert property (p_high_wins)
      else $error("flash selected under ram, io or peripheral");

   property p_prim_fetch_gate;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && upd && fetch_act && !rd_act && !wr_act &&
       !space_map_reg[msd_pkg::MAP_PRIM_CODE]) |=>
         O_PRIMARY_SECTOR_SELECTS == '0;
   endproperty
   a_prim_fetch_gate: assert property (p_prim_fetch_gate)
      else $error("primary flash selected on fetch without map bit");

   property p_ram_fetch_gate;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && upd && fetch_act && !rd_act && !wr_act &&
       !space_map_reg[msd_pkg::MAP_RAM_CODE]) |=> !O_RAM_SELECT;
   endproperty
   a_ram_fetch_gate: assert property (p_ram_fetch_gate)
      else $error("ram selected on fetch without map bit");

   property p_page_write;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && wr_pulse && page_hit) |=> page_reg == $past(s_data);
   endproperty
   a_page_write: assert property (p_page_write)
      else $error("page register missed a write");

   property p_page_read;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && rd_act && page_hit) |=>
         (O_DATA_OE && O_DATA == $past(page_reg));
   endproperty
   a_page_read: assert property (p_page_read)
      else $error("page register read-back wrong");

   property p_standby_enter;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && upd && !I_FAST_MODE && !changed &&
       idle_reg == STBY_LAST) |=> (pwr_reg == msd_pkg::PWR_STANDBY);
   endproperty
   a_standby_enter: assert property (p_standby_enter)
      else $error("array did not enter standby after quiet time");

   property p_standby_hold;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (pwr_reg == msd_pkg::PWR_STANDBY) |=>
         ($stable(O_PRIMARY_SECTOR_SELECTS) && $stable(O_RAM_SELECT));
   endproperty
   a_standby_hold: assert property (p_standby_hold)
      else $error("selects changed while array in standby");

   property p_ext_addr;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_EXT_ADDR_MODE |-> arr_bus[15:0] == s_addr[19:4];
   endproperty
   a_ext_addr: assert property (p_ext_addr)
      else $error("extended address mode not applied");

   property p_ctrl_block;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_CTRL_BLOCK[msd_pkg::BLK_FETCH] |-> !arr_bus[msd_pkg::BUS_FETCH];
   endproperty
   a_ctrl_block: assert property (p_ctrl_block)
      else $error("blocked fetch strobe reached the array");

   property p_pio_gate;
      @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLK_EN && upd && !space_map_reg[msd_pkg::MAP_PERIPHERAL_IO_MODE_ENABLE]) |=>
         O_PERIPH_SELECTS == '0;
   endproperty
   a_pio_gate: assert property (p_pio_gate)
      else $error("peripheral select outside peripheral io mode");

   c_ram_sel:   cover property (@(posedge I_REF_CLK) O_RAM_SELECT);
   c_sec_sel:   cover property (@(posedge I_REF_CLK)
                   |O_SECONDARY_SECTOR_SELECTS);
   c_standby:   cover property (@(posedge I_REF_CLK)
                   pwr_reg == msd_pkg::PWR_STANDBY);
   c_page_wr:   cover property (@(posedge I_REF_CLK)
                   I_CLK_EN && wr_pulse && page_hit);

endmodule // msd_decoder

// ==== testbench/msd_mcu_model.sv ====
// bus model of the mcu that drives the decoder pins
`timescale 1ns/1ps

module msd_mcu_model (
   // clock and observed device outputs
   input  wire logic        i_clk,
   input  wire logic [15:0] i_obs,
   // mcu bus pins
   output logic      [19:0] o_addr,
   output logic      [7:0]  o_data,
   output logic             o_wr_n,
   output logic             o_rd_n,
   output logic             o_fetch_n
);
   // idle bus: strobes high, other lines start at a known level
   initial begin
      o_addr = 20'h00000;
      o_data = 8'h00;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_fetch_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // one access: kind 0 write, 1 data read, 2 program fetch; the map may
   // be rewritten at any time, so no access ever waits for a quiet bus
   task automatic access(input logic [19:0] a, input logic [7:0] d,
                         input int k, output logic [15:0] obs);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_data = d;
      o_wr_n = (k != 0);
      o_rd_n = (k != 1);
      o_fetch_n = (k != 2);
      // fifth edge covers the sync stages plus one standby wake cycle
      repeat (5) @(posedge i_clk);
      obs = i_obs;
      @(posedge i_clk);
      #1;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_fetch_n = 1'b1;
      // released lines must not keep showing the old value
      o_addr = ~a;
      o_data = ~d;
      repeat (4) @(posedge i_clk);
   endtask
endmodule // msd_mcu_model

// ==== testbench/tb_top.sv ====
// self-checking bench of the memory space decoder
`timescale 1ns/1ps

module tb_top;
   localparam int BW = msd_pkg::BUS_W;
   localparam int NT = msd_pkg::NUM_TERMS;
   // one field of one product term, as mask (m=1) or compare value
   function automatic logic [NT*BW-1:0] tm(input int t, input int l,
                                           input int w, input int v,
                                           input bit m);
      logic [NT*BW-1:0] r;
      r = '0;
      r[t*BW+l +: 8] = m ? 8'(2**w-1) : 8'(v);
      return r;
   endfunction
   // prim0 8000-BFFF, prim1 C000-FFFF with page bit 0, sec0 8000-9FFF,
   // ram 8000-87FF, config window 7F00-7FFF, jtag on the fetch line,
   // peripheral 0 at 4000-4FFF
   localparam logic [NT*BW-1:0] MK = tm(0,14,2,2,1) | tm(3,14,2,3,1) |
      tm(3,48,1,1,1) | tm(24,13,3,4,1) | tm(36,11,5,16,1) | tm(38,8,8,127,1)
      | tm(39,18,1,1,1) | tm(40,12,4,4,1);
   localparam logic [NT*BW-1:0] VL = tm(0,14,2,2,0) | tm(3,14,2,3,0) |
      tm(3,48,1,1,0) | tm(24,13,3,4,0) | tm(36,11,5,16,0) | tm(38,8,8,127,0)
      | tm(39,18,1,1,0) | tm(40,12,4,4,0);
   localparam logic [NT-1:0] EN = (NT'(1) << 0) | (NT'(1) << 3) |
      (NT'(1) << 24) | (NT'(1) << 36) | (NT'(1) << 38) | (NT'(1) << 39) |
      (NT'(1) << 40);
   logic clk = 1'b0, rst_n = 1'b0, ext = 1'b0, fast = 1'b1;
   logic [4:0] blk = 5'h00;
   logic [2:0] pd = 3'h0;
   logic [23:0] pm = 24'h000000;
   logic [15:0] fb = 16'h0000;
   logic [19:0] addr;
   logic [7:0] dout, din, page, map, po;
   logic [3:0] so;
   logic [1:0] ps;
   logic [15:0] ob, obs;
   logic wr_n, rd_n, fe_n, oe, pio, stby, rs, jt, cf;
   int mismatches = 0, n_compared = 0;
   always #2 clk = ~clk;
   msd_mcu_model i_mcu (.i_clk(clk), .i_obs(obs), .o_addr(addr),
      .o_data(din), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_fetch_n(fe_n));
   // bit 7 set, bits 5 and 6 set too so the boot mask is seen
   msd_decoder #(.TERM_MASK(MK), .TERM_VALUE(VL), .TERM_EN(EN)) i_dut (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1), .I_ADDR(addr),
      .I_DATA(din), .O_DATA(dout), .O_DATA_OE(oe),
      .I_WRITE_STROBE_N(wr_n), .I_BUS_CONTROL_LINE_1_N(rd_n),
      .I_PROGRAM_FETCH_STROBE_N(fe_n), .I_MCU_RESET_N(1'b1),
      .I_POWER_DOWN_INPUT(1'b0), .I_PORT_MACROCELLS(pm), .I_PORT_D(pd),
      .I_MACROCELL_FB(fb), .I_SECONDARY_READY(1'b1),
      .I_SPACE_MAP_INIT(8'hE5), .I_EXT_ADDR_MODE(ext), .I_FAST_MODE(fast),
      .I_CTRL_BLOCK(blk), .O_PRIMARY_SECTOR_SELECTS(po),
      .O_SECONDARY_SECTOR_SELECTS(so), .O_RAM_SELECT(rs),
      .O_CONFIG_REG_WINDOW(cf), .O_JTAG_SELECT(jt), .O_PERIPH_SELECTS(ps),
      .O_PAGE_BITS(page), .O_PERIPHERAL_IO_MODE_ENABLE(pio),
      .O_ARRAY_STANDBY(stby));
   assign obs = {ps[0], cf, jt, oe, dout, rs, so[0], po[1:0]};
   ////////////////////////////////////////////////////////////////////////
   // expected {ram, sec0, prim0}: ram wins, then secondary, then primary
   function automatic logic [2:0] exp_sel(input logic [15:0] a,
                                          input logic f, input logic [7:0] m);
      logic r, s, p;
      r = (a[15:11] == 5'h10);
      s = (a[15:13] == 3'h4);
      p = (a[15:14] == 2'h2);
      return {r & (!f | m[0]), s & !r & (f ? m[1] : m[3]),
              p & !s & !r & (f ? m[2] : m[4])};
   endfunction
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   // array inputs that no term uses still change, to exercise the bus
   task automatic acc(input logic [19:0] a, input logic [7:0] d, input int k);
      #1;
      pm = 24'($urandom);
      fb = 16'($urandom);
      pd = 3'($urandom);
      i_mcu.access(a, d, k, ob);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      mismatches++;
      complete_run;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(497));
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      acc(20'h07FE2, 8'h00, 1);
      chk("boot map", 8'h85, ob[11:4]);
      chk("cfg sel", 8'h01, {7'h00, ob[14]});
      chk("pio", 8'h01, {7'h00, pio});
      chk("page rst", 8'h00, page);
      for (int i = 0; i < 4; i++) begin
         map = (i == 0) ? 8'h01 : 8'($urandom);
         acc(20'h07FE0, map, 0);
         acc(20'h07FE0, 8'h00, 1);
         chk("page rd", map, ob[11:4]);
         chk("page out", map, page);
         acc(20'h0C000, 8'h00, 2);
         chk("paged prim1", {7'h00, map[0]}, {7'h00, ob[1]});
      end
      acc(20'h07FE2, 8'hFF, 0);
      acc(20'h07FE2, 8'h00, 1);
      chk("map unused", 8'h9F, ob[11:4]);
      acc(20'h07FE4, 8'h00, 1);
      chk("unmapped oe", 8'h00, {7'h00, ob[12]});
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         map = (i == 0) ? 8'h0C : (i == 1) ? 8'h14 : 8'($urandom) & 8'h9F;
         acc(20'h07FE2, map, 0);
         for (int k = 1; k < 3; k++)
            for (int j = 0; j < 8; j++) begin
               logic [15:0] a;
               a = (j % 4 == 0) ? 16'h8100 : (j % 4 == 1) ? 16'h9000 :
                   (j % 4 == 2) ? 16'hA000 : 16'h4000;
               acc({4'h0, a}, 8'h00, k);
               chk("sel", {4'h0, (a[15:12] == 4'h4 && map[7]),
                  exp_sel(a, k == 2, map)}, {4'h0, ob[15], ob[3:2], ob[0]});
            end
      end
      $display("test decode done");
      acc(20'h07FE2, 8'h1F, 0);
      #1 ext = 1'b1;
      acc(20'hA0000, 8'h00, 2);
      chk("ext sel", 8'h09, {4'h0, ob[13], ob[3:2], ob[0]});
      #1 ext = 1'b0;
      blk = 5'h04;
      acc(20'h0A000, 8'h00, 2);
      chk("blocked", 8'h01, {4'h0, ob[13], ob[3:2], ob[0]});
      #1 blk = 5'h00;
      $display("test modes done");
      fast = 1'b0;
      repeat (24) @(posedge clk);
      chk("standby", 8'h01, {7'h00, stby});
      acc(20'h09000, 8'h00, 1);
      chk("wake sel", 8'h02, {5'h00, ob[3:2], ob[0]});
      $display("test standby done");
      complete_run;
   end
endmodule // tb_top
